// file: logic/pmic_cmd_port.sv
// two-wire command port of the power manager, regulator control
// and the all-rails-good output; status over an AHB-Lite slave
// assumes link_clk oversamples scl well above the bit rate
//
// Operation
// [RULE1] mode bits set the buck mode and buck-boost pwm or hysteretic.
// [RULE2] a write opens with start, address and write bit; ack on match.
// [RULE3] exactly two data bytes follow, high byte first, each acked.
// [RULE4] each data byte enters a holding latch as its ack is driven.
// [RULE5] a stop or repeated start may follow; held data survives.
// [RULE6] a stop after complete data loads the command latch.
// [RULE7] a stop during an incomplete transfer is ignored.
// [RULE8] pending complete data is applied on the next stop not held by [RULE9].
// [RULE9] once address and first byte are acked, stops wait for byte two.
// [RULE10] with the logic supply pin low, only pins control the rails.
// [RULE11] port off: servos 0.8 V, pulse skip, pwm, input limit 1x.
// [RULE12] rails-good stays low until rails reach 92 %, then 230 ms more.
// [RULE13] rails-good is open drain: pulled low or released only.
// [RULE14] all-enable turns on every rail; the port enables each alone.
// [RULE15] buck one servo programmable, 0.8 V with port off; buck two fixed.
// [RULE16] no ack on mismatch or read; later bytes ignored until start.
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module pmic_cmd_port
  import pmic_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT,
  parameter int PGOOD_CYC = PGOOD_DELAY_CYC
)
(
  // system
  input wire logic ref_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // two-wire link
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // pins
  input wire logic serial_port_logic_supply,
  input wire logic enable_every_regulator_pin,
  input wire logic power_up_order_pin,
  input wire logic [2:0] rail_reached_92pct,
  input wire logic all_rails_good_in,
  output logic all_rails_good_out,
  output logic all_rails_good_oe,
  // regulator control
  output logic buck1_en,
  output logic buck2_en,
  output logic bb_en,
  output logic [3:0] buck_mode,
  output logic bb_hyst,
  output logic [3:0] buck1_servo,
  output logic [3:0] bb_servo,
  output logic charger_dis,
  output logic [1:0] usb_ilim,
  output logic power_up_order
);

  localparam int CW = $clog2(PGOOD_CYC + 1);
  localparam logic [CW-1:0] PG_MAX = CW'(PGOOD_CYC);

  function automatic logic [3:0] mode_dec(input logic [1:0] m);
    unique case (m)
      MODE_PSKIP: mode_dec = BM_PSKIP;
      MODE_AUTO: mode_dec = BM_AUTO;
      MODE_FORCED: mode_dec = BM_FORCED;
      MODE_LDO: mode_dec = BM_LDO;
    endcase
  endfunction

  // =====================================================
  // link domain: sampling and bus conditions
  logic [3:0] lsync;
  logic lrst_n, lsup, scl_s, sda_s;
  logic scl_p_q, sda_p_q;
  logic start_det, stop_det, scl_rise, scl_fall;

  pmic_sync #(.W(4)) u_lsync (
    .clk(link_clk),
    .din({rst_n, serial_port_logic_supply, scl_in, sda_in}),
    .dout(lsync)
  );

  assign {lrst_n, lsup, scl_s, sda_s} = lsync;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;

  // =====================================================
  // link domain: receiver
  pmic_lst_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, hold_hi_q, hold_hi_d;
  logic [15:0] hold_q, hold_d, lcmd_q, lcmd_d;
  logic sec_q, sec_d, oe_q, oe_d;
  logic pend_q, pend_d, busy_q, busy_d, tgl_q, tgl_d;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    hold_hi_d = hold_hi_q;
    hold_d = hold_q;
    lcmd_d = lcmd_q;
    sec_d = sec_q;
    oe_d = oe_q;
    pend_d = pend_q;
    busy_d = busy_q;
    tgl_d = tgl_q;
    if (start_det)
    begin
      st_d = ST_ADDR; // [RULE2]
      cnt_d = 4'h0;
      oe_d = 1'b0;
      busy_d = 1'b0; // [RULE7]
    end
    else if (stop_det)
    begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      // a stop mid-transfer leaves the held word alone
      if (!busy_q && pend_q) // [RULE6] [RULE7] [RULE8] [RULE9]
      begin
        lcmd_d = hold_q;
        pend_d = 1'b0;
        tgl_d = ~tgl_q;
      end
    end
    else
    begin
      unique case (st_q)
        ST_IDLE, ST_IGN:
        begin
        end
        ST_ADDR, ST_DATA:
        begin
          if (scl_rise)
          begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == 4'h8)
          begin
            if (st_q == ST_DATA)
            begin
              oe_d = 1'b1; // [RULE3]
              st_d = ST_DACK;
              if (!sec_q)
              begin
                hold_hi_d = sh_q; // [RULE4]
                busy_d = 1'b1; // [RULE9]
              end
              else
              begin
                hold_d = {hold_hi_q, sh_q}; // [RULE4] [RULE5]
                pend_d = 1'b1;
                busy_d = 1'b0;
              end
            end
            else if (sh_q[7:1] == DEV_ADDR && !sh_q[0]) // [RULE2]
            begin
              oe_d = 1'b1;
              st_d = ST_AACK;
              sec_d = 1'b0;
            end
            else
            begin
              st_d = ST_IGN; // [RULE16]
            end
          end
        end
        ST_AACK, ST_DACK:
        begin
          if (scl_fall)
          begin
            oe_d = 1'b0;
            cnt_d = 4'h0;
            // a third byte is not acknowledged
            st_d = (st_q == ST_DACK && sec_q) ? ST_IGN : ST_DATA; // [RULE3]
            sec_d = (st_q == ST_DACK);
          end
        end
        default:
        begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
    if (!lsup) // [RULE10]
    begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      hold_hi_q <= 8'h00;
      hold_q <= CMD_RST;
      lcmd_q <= CMD_RST;
      sec_q <= 1'b0;
      oe_q <= 1'b0;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      tgl_q <= 1'b0;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      hold_hi_q <= hold_hi_d;
      hold_q <= hold_d;
      lcmd_q <= lcmd_d;
      sec_q <= sec_d;
      oe_q <= oe_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
      tgl_q <= tgl_d;
    end
  end

  assign sda_oe = oe_q;
  assign sda_out = 1'b0;

  // =====================================================
  // reference domain: pins and command crossing
  logic [7:0] rsync;
  logic tgl_s, sup_s, allon_s, ord_s, pgin_s;
  logic [2:0] rails_s;
  logic tgl_p_q;
  logic [15:0] cmd_q, cmd_d;

  pmic_sync #(.W(8)) u_rsync (
    .clk(ref_clk),
    .din({tgl_q, serial_port_logic_supply, enable_every_regulator_pin,
          power_up_order_pin, rail_reached_92pct, all_rails_good_in}),
    .dout(rsync)
  );

  assign {tgl_s, sup_s, allon_s, ord_s, rails_s, pgin_s} = rsync;

  // lcmd_q only changes a whole transaction, on the same link_clk edge as its toggle
  assign cmd_d = (tgl_s ^ tgl_p_q) ? lcmd_q : cmd_q;

  // =====================================================
  // reference domain: regulator control
  logic port_q, port_d, en1_q, en1_d, en2_q, en2_d, en3_q, en3_d;
  logic hyst_q, hyst_d, chg_q, chg_d, ord_q, ord_d;
  logic [3:0] bmode_q, bmode_d, sv1_q, sv1_d, sv3_q, sv3_d;
  logic [1:0] ilim_q, ilim_d, mode;

  always_comb
  begin
    port_d = sup_s;
    mode = sup_s ? cmd_q[CMD_MODE_HI:CMD_MODE_LO] : MODE_PSKIP; // [RULE11]
    bmode_d = mode_dec(mode); // [RULE1]
    hyst_d = (mode == MODE_FORCED); // [RULE1]
    en1_d = allon_s | (sup_s & cmd_q[CMD_EN1]); // [RULE14]
    en2_d = allon_s | (sup_s & cmd_q[CMD_EN2]); // [RULE14]
    en3_d = allon_s | (sup_s & cmd_q[CMD_EN3]); // [RULE14]
    sv1_d = sup_s ? cmd_q[CMD_SERVO1_LSB +: 4] : SERVO_0V8; // [RULE15]
    sv3_d = sup_s ? cmd_q[CMD_SERVO3_LSB +: 4] : SERVO_0V8; // [RULE11]
    chg_d = sup_s & cmd_q[CMD_CHG_DIS]; // [RULE10]
    ilim_d = sup_s ? cmd_q[CMD_ILIM_LSB +: 2] : ILIM_1X; // [RULE11]
    ord_d = ord_s; // [RULE10]
  end

  // =====================================================
  // reference domain: all-rails-good timer
  logic [CW-1:0] pg_q, pg_d;
  logic pgoe_q, pgoe_d, ctrl_q, ctrl_d, all_ok;
  logic [2:0] en_all;

  assign en_all = {en3_q, en2_q, en1_q};
  assign all_ok = (en_all != 3'h0) && ((rails_s & en_all) == en_all)
    && !ctrl_q;

  always_comb
  begin
    if (!all_ok)
      pg_d = '0;
    else if (pg_q == PG_MAX)
      pg_d = pg_q;
    else
      pg_d = pg_q + CW'(1);
    pgoe_d = (pg_d != PG_MAX); // [RULE12] [RULE13]
  end

  // =====================================================
  // ahb-lite slave, zero wait states
  logic aw_q, aw_d, hrdy_q;
  logic [7:0] aa_q, aa_d;
  logic [31:0] rd_q, rd_d;
  logic take, fwd;

  function automatic logic [31:0] rd_mux(input logic [31:0] a,
                                         input logic c);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a[31:8] == 24'h00_0000)
    begin
      unique case (a[7:0])
        OFS_CTRL: r[0] = c;
        OFS_STAT:
        begin
          r[STAT_PORT_EN] = port_q;
          r[STAT_PG_REL] = ~pgoe_q;
          r[STAT_PG_PIN] = pgin_s;
          r[STAT_RAILS_LSB +: 3] = rails_s;
          r[STAT_EN_LSB +: 3] = en_all;
        end
        OFS_CMD: r[15:0] = cmd_q;
        default: r = 32'h0000_0000;
      endcase
    end
    rd_mux = r;
  endfunction

  assign take = hsel & htrans[1] & hready;
  assign fwd = aw_q & (aa_q == OFS_CTRL);

  always_comb
  begin
    aw_d = take & hwrite;
    aa_d = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
    ctrl_d = fwd ? hwdata[0] : ctrl_q;
    rd_d = take ? rd_mux(haddr, ctrl_d) : rd_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tgl_p_q <= 1'b0;
      cmd_q <= CMD_RST;
      port_q <= 1'b0;
      en1_q <= 1'b0;
      en2_q <= 1'b0;
      en3_q <= 1'b0;
      hyst_q <= 1'b0;
      chg_q <= 1'b0;
      ord_q <= 1'b0;
      bmode_q <= BM_PSKIP;
      sv1_q <= SERVO_0V8;
      sv3_q <= SERVO_0V8;
      ilim_q <= ILIM_1X;
      pg_q <= '0;
      pgoe_q <= 1'b1;
      ctrl_q <= CTRL_RST;
      aw_q <= 1'b0;
      aa_q <= 8'h00;
      rd_q <= 32'h0000_0000;
      hrdy_q <= 1'b1;
    end
    else
    begin
      tgl_p_q <= tgl_s;
      cmd_q <= cmd_d;
      port_q <= port_d;
      en1_q <= en1_d;
      en2_q <= en2_d;
      en3_q <= en3_d;
      hyst_q <= hyst_d;
      chg_q <= chg_d;
      ord_q <= ord_d;
      bmode_q <= bmode_d;
      sv1_q <= sv1_d;
      sv3_q <= sv3_d;
      ilim_q <= ilim_d;
      pg_q <= pg_d;
      pgoe_q <= pgoe_d;
      ctrl_q <= ctrl_d;
      aw_q <= aw_d;
      aa_q <= aa_d;
      rd_q <= rd_d;
      hrdy_q <= 1'b1;
    end
  end

  assign hrdata = rd_q;
  assign hreadyout = hrdy_q;
  assign hresp = 1'b0;
  assign all_rails_good_out = 1'b0;
  assign all_rails_good_oe = pgoe_q;
  assign buck1_en = en1_q;
  assign buck2_en = en2_q;
  assign bb_en = en3_q;
  assign buck_mode = bmode_q;
  assign bb_hyst = hyst_q;
  assign buck1_servo = sv1_q;
  assign bb_servo = sv3_q;
  assign charger_dis = chg_q;
  assign usb_ilim = ilim_q;
  assign power_up_order = ord_q;

  // =====================================================
  // checks
  sequence s_stop_apply;
    stop_det && !start_det && !busy_q && pend_q && lsup;
  endsequence
  sequence s_stop_busy;
    stop_det && !start_det && busy_q;
  endsequence

  a_mode_ldo: assert property (@(posedge ref_clk) // [RULE1]
    disable iff (!rst_n)
    sup_s && cmd_q[CMD_MODE_HI:CMD_MODE_LO] == MODE_LDO
    |=> bmode_q == BM_LDO)
    else $error("linear mode not decoded");
  a_addr_nak: assert property (@(posedge link_clk) // [RULE16]
    disable iff (!lrst_n)
    st_q == ST_IGN |-> !oe_q)
    else $error("ack driven while ignoring");
  a_ack_cause: assert property (@(posedge link_clk) // [RULE2]
    disable iff (!lrst_n)
    $rose(oe_q) |-> $past(scl_fall) && (st_q == ST_AACK || st_q == ST_DACK))
    else $error("ack outside an ack slot");
  a_byte_latch: assert property (@(posedge link_clk) // [RULE4]
    disable iff (!lrst_n)
    st_q == ST_DATA && scl_fall && cnt_q == 4'h8 && !sec_q && !stop_det
    && !start_det && lsup |=> hold_hi_q == $past(sh_q) && oe_q)
    else $error("first byte not latched at ack");
  a_stop_apply: assert property (@(posedge link_clk) // [RULE6]
    disable iff (!lrst_n)
    s_stop_apply |=> lcmd_q == $past(hold_q) && !pend_q
    && tgl_q != $past(tgl_q))
    else $error("held word not applied on stop");
  a_stop_ignore: assert property (@(posedge link_clk) // [RULE9]
    disable iff (!lrst_n)
    s_stop_busy |=> $stable(lcmd_q) && $stable(tgl_q))
    else $error("stop applied mid-transfer");
  a_port_nak: assert property (@(posedge link_clk) // [RULE10]
    disable iff (!lrst_n)
    !lsup |=> !oe_q && st_q == ST_IDLE)
    else $error("link active with port off");
  a_port_off: assert property (@(posedge ref_clk) // [RULE11]
    disable iff (!rst_n)
    !sup_s |=> sv1_q == SERVO_0V8 && bmode_q == BM_PSKIP && !hyst_q
    && ilim_q == ILIM_1X && !chg_q)
    else $error("port-off defaults wrong");
  a_all_enable: assert property (@(posedge ref_clk) // [RULE14]
    disable iff (!rst_n)
    allon_s |=> en1_q && en2_q && en3_q)
    else $error("all-enable did not enable rails");
  a_pg_low: assert property (@(posedge ref_clk) // [RULE12]
    disable iff (!rst_n)
    !all_ok |=> pgoe_q [*2])
    else $error("rails-good released early");

endmodule // pmic_cmd_port

// file: logic/pmic_pkg.sv
// constants shared by the command port and its synchroniser
// assumes a 25 MHz reference clock and an oversampling link clock
package pmic_pkg;

  // =====================================================
  // identity and bus map
  // arbitrary neutral value, not a real part address
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic CTRL_RST = 1'h0;

  // =====================================================
  // command word fields
  localparam int CMD_SERVO1_LSB = 12;
  localparam int CMD_SERVO3_LSB = 8;
  localparam int CMD_EN1 = 7;
  localparam int CMD_MODE_HI = 6;
  localparam int CMD_MODE_LO = 5;
  localparam int CMD_EN2 = 4;
  localparam int CMD_EN3 = 3;
  localparam int CMD_CHG_DIS = 2;
  localparam int CMD_ILIM_LSB = 0;
  localparam logic [15:0] CMD_RST = 16'hFF00;

  // =====================================================
  // status word fields
  localparam int STAT_PORT_EN = 0;
  localparam int STAT_PG_REL = 1;
  localparam int STAT_PG_PIN = 2;
  localparam int STAT_RAILS_LSB = 3;
  localparam int STAT_EN_LSB = 6;

  // =====================================================
  // mode codes and defaults
  localparam logic [1:0] MODE_PSKIP = 2'h0;
  localparam logic [1:0] MODE_FORCED = 2'h1;
  localparam logic [1:0] MODE_LDO = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  localparam logic [3:0] BM_PSKIP = 4'h1;
  localparam logic [3:0] BM_AUTO = 4'h2;
  localparam logic [3:0] BM_FORCED = 4'h4;
  localparam logic [3:0] BM_LDO = 4'h8;
  localparam logic [3:0] SERVO_0V8 = 4'hF;
  localparam logic [1:0] ILIM_1X = 2'h0;

  // =====================================================
  // timing
  localparam int PGOOD_DELAY_MS = 230;
  localparam int REF_CLK_HZ = 25_000_000;
  localparam int PGOOD_DELAY_CYC = PGOOD_DELAY_MS * (REF_CLK_HZ / 1000);

  // =====================================================
  // link receiver states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_AACK = 6'h04,
    ST_DATA = 6'h08,
    ST_DACK = 6'h10,
    ST_IGN = 6'h20
  } pmic_lst_t;

endpackage

// file: logic/pmic_sync.sv
// two-flop level synchroniser, one bit per lane
// assumes every lane is a slow level or a toggle
`timescale 1ns/1ns
module pmic_sync
  import pmic_pkg::*;
#(
  parameter int W = 1
)
(
  // clock
  input wire logic clk,
  // lanes
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // no reset: also used to bring the reset itself across
  always_ff @(posedge clk)
  begin
    meta_q <= din;
    sync_q <= meta_q;
  end

  assign dout = sync_q;

endmodule // pmic_sync

// file: tb/pmic_i2c_master.sv
// behavioural two-wire bus master for the command port bench
// assumes an open-drain sda with pull-up resolved by the bench
`timescale 1ns/1ns
module pmic_i2c_master
(
  // wire
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam int Q = 120;
  // ==================================================
  // bus conditions
  // scl stands high while idle and after a stop, as on a real bus
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // msb first, ack sampled while scl is high
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_low = ~b[i];
      #Q scl = 1'b1;
      #Q scl = 1'b0;
      #Q;
    end
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q ack = ~sda;
    scl = 1'b0;
    #Q;
  endtask
endmodule // pmic_i2c_master

// file: tb/tb.sv
// self-checking bench for the command port
// assumes the designer's note: zero-wait slave, toggle crossing
`timescale 1ns/1ns
module tb;
  import pmic_pkg::*;
  localparam int PG = 20;
  localparam logic [7:0] AW = {DEV_ADDR_DFLT, 1'b0};
  logic ref_clk = 0, link_clk = 0, rst_n = 0;
  logic hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, sda_out, sda_oe, scl, sda_low, sda;
  logic supply = 1, all_en = 0, order = 0;
  logic [2:0] rails = 0;
  logic pg_out, pg_oe, b1, b2, bb, hyst, chg, ord_o;
  logic [3:0] mode, sv1, sv3;
  logic [1:0] ilim;
  logic [15:0] w, last;
  int err_total = 0, checked = 0;
  assign hready = hreadyout;
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  always #20 ref_clk = ~ref_clk;
  initial #1 forever #3 link_clk = ~link_clk;
  pmic_cmd_port #(.PGOOD_CYC(PG)) u_pmic_cmd_port (.ref_clk(ref_clk),
    .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .link_clk(link_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .serial_port_logic_supply(supply),
    .enable_every_regulator_pin(all_en), .power_up_order_pin(order),
    .rail_reached_92pct(rails), .all_rails_good_in(~pg_oe),
    .all_rails_good_out(pg_out), .all_rails_good_oe(pg_oe),
    .buck1_en(b1), .buck2_en(b2), .bb_en(bb), .buck_mode(mode),
    .bb_hyst(hyst), .buck1_servo(sv1), .bb_servo(sv3),
    .charger_dis(chg), .usb_ilim(ilim), .power_up_order(ord_o));
  pmic_i2c_master u_pmic_i2c_master (.scl(scl), .sda_low(sda_low),
    .sda(sda));
  // ==================================================
  // checking and closing
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [18:0] exp_vec(input logic [15:0] c);
    logic [3:0] bm;
    case (c[6:5])
      2'b00: bm = BM_PSKIP;
      2'b01: bm = BM_FORCED;
      2'b10: bm = BM_LDO;
      default: bm = BM_AUTO;
    endcase
    return {c[7], c[4], c[3], bm, c[6:5] == 2'b01, c[15:8], c[2:0]};
  endfunction
  task automatic outs(input logic [18:0] e, input string m);
    chk(32'({b1, b2, bb, mode, hyst, sv1, sv3, chg, ilim}), 32'(e), m);
  endtask
  // ==================================================
  // bus tasks
  task automatic rdy();
    int n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    rd = hrdata;
    chk(32'(hresp), 32'h0000_0000, "okay response");
  endtask
  task automatic frame(input logic [7:0] ab, input logic [15:0] c,
                       input int nb, input logic ea);
    logic k;
    u_pmic_i2c_master.start();
    u_pmic_i2c_master.wbyte(ab, k);
    chk(32'(k), 32'(ea), "address ack");
    for (int i = 0; i < nb; i++)
    begin
      u_pmic_i2c_master.wbyte(i == 0 ? c[15:8] : c[7:0], k);
      chk(32'(k), 32'(ea), "data ack");
    end
  endtask
  task automatic fin(input string t);
    repeat (14) @(posedge ref_clk);
    $display("test %s done", t);
  endtask
  function automatic logic [15:0] rw();
    return 16'($urandom());
  endfunction
  initial
  begin
    #500_000;
    err_total++;
    end_sim();
  end
  // ==================================================
  // main sequence
  initial
  begin
    void'($urandom(32'hd7041f46));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    order <= 1'($urandom());
    fin("reset");
    outs(exp_vec(CMD_RST), "reset outputs");
    chk(32'(pg_oe), 32'h0000_0001, "rails-good held low");
    chk(32'(ord_o), 32'(order), "order pin follows");
    ahb(1'b0, 32'(OFS_CMD), 0);
    chk(rd, 32'(CMD_RST), "reset command");
    ahb(1'b0, 32'h0000_000C, 0);
    chk(rd, 32'h0000_0000, "unmapped read");
    for (int m = 0; m < 4; m++)
    begin
      w = rw();
      w[6:5] = 2'(m);
      frame(AW, w, 2, 1'b1);
      u_pmic_i2c_master.stop();
      fin("mode");
      outs(exp_vec(w), "applied word");
      ahb(1'b0, 32'(OFS_CMD), 0);
      chk(rd, {16'h0000, w}, "command readback");
    end
    last = w;
    frame({DEV_ADDR_DFLT, 1'b1}, rw(), 2, 1'b0);
    u_pmic_i2c_master.stop();
    frame(AW ^ 8'h02, rw(), 2, 1'b0);
    u_pmic_i2c_master.stop();
    fin("refuse");
    outs(exp_vec(last), "no change on refusal");
    frame(AW, rw(), 1, 1'b1);
    u_pmic_i2c_master.stop();
    fin("partial");
    outs(exp_vec(last), "partial ignored");
    last = rw();
    frame(AW, last, 2, 1'b1);
    frame(AW ^ 8'h04, rw(), 2, 1'b0);
    frame(AW ^ 8'h08, rw(), 2, 1'b0);
    u_pmic_i2c_master.stop();
    fin("pending");
    outs(exp_vec(last), "pending applied");
    frame(AW, rw(), 2, 1'b1);
    frame(AW, rw(), 1, 1'b1);
    u_pmic_i2c_master.stop();
    fin("busy");
    outs(exp_vec(last), "stop while busy");
    w = rw();
    frame(AW, w, 2, 1'b1);
    u_pmic_i2c_master.stop();
    fin("recover");
    outs(exp_vec(w), "new word");
    supply <= 1'b0;
    order <= ~order;
    all_en <= 1'b1;
    fin("port off");
    frame(AW, rw(), 2, 1'b0);
    u_pmic_i2c_master.stop();
    fin("port off frame");
    outs({3'b111, BM_PSKIP, 1'b0, SERVO_0V8, SERVO_0V8, 1'b0, ILIM_1X},
         "port off defaults");
    chk(32'(ord_o), 32'(order), "order pin with port off");
    chk(32'(pg_oe), 32'h0000_0001, "no rails yet");
    chk(32'(pg_out), 32'h0000_0000, "drives low only");
    rails <= 3'b111;
    repeat (PG) @(posedge ref_clk);
    chk(32'(pg_oe), 32'h0000_0001, "delay not over");
    repeat (15) @(posedge ref_clk);
    chk(32'(pg_oe), 32'h0000_0000, "released after delay");
    ahb(1'b0, 32'(OFS_STAT), 0);
    chk(rd, 32'((1 << STAT_PG_REL) | (1 << STAT_PG_PIN)
        | (7 << STAT_RAILS_LSB) | (7 << STAT_EN_LSB)), "status word");
    ahb(1'b1, 32'(OFS_CTRL), 32'h0000_0001);
    ahb(1'b0, 32'(OFS_CTRL), 0);
    chk(rd, 32'h0000_0001, "control readback");
    repeat (4) @(posedge ref_clk);
    chk(32'(pg_oe), 32'h0000_0001, "forced low");
    ahb(1'b1, 32'(OFS_CTRL), 32'h0000_0000);
    fin("rails good");
    end_sim();
  end
endmodule // tb
